// File: rtl/bssu_top.sv
`timescale 1ns/1ps
`include "bssu_consts.svh"
module bssu_top
(
  input  wire logic                    i_clock,
  input  wire logic                    i_nrst,
  input  wire logic                    i_valid,
  input  wire bssu_pkg::bssu_req_s     i_req,
  output logic                         o_valid,
  output logic [`BSSU_WORD_W-1:0]      o_result,
  output logic                         o_overflow
);
  // =====================================================
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // =====================================================
  // Datapath helpers

  // Counts above the word width act as the full width
  function automatic logic [5:0] sat_count(input logic [`BSSU_CNT_W-1:0] c);
    if (c > `BSSU_CNT_W'(`BSSU_MAX_SHIFT))
    begin
      sat_count = 6'(`BSSU_MAX_SHIFT);
    end
    else
    begin
      sat_count = c[5:0];
    end
  endfunction

  // Sign-extended left shift: low word is the result, high word what left it
  function automatic logic [63:0] shift_left(input logic [`BSSU_WORD_W-1:0] s,
                                             input logic [5:0]              n);
    shift_left = {{`BSSU_WORD_W{s[`BSSU_WORD_W-1]}}, s} << n;
  endfunction

  // Right shift with a chosen fill: high word is the result, low word what left it
  function automatic logic [63:0] shift_right(input logic [`BSSU_WORD_W-1:0] s,
                                              input logic [5:0]              n,
                                              input logic                    fill);
    logic [64:0] ext;
    ext         = {fill, s, 32'h0000_0000};
    shift_right = 64'($signed(ext) >>> n);
  endfunction

  // Every bit pushed out, and the new sign, must match the source sign
  function automatic logic left_overflow(input logic [63:0] w,
                                         input logic        sgn);
    left_overflow = (w[63:31] != {33{sgn}});
  endfunction

  // A negative source that lost set bits is bumped up by one
  function automatic logic [`BSSU_WORD_W-1:0] round_to_zero(input logic [63:0] w,
                                                            input logic        sgn);
    logic inexact;
    inexact       = |w[31:0];
    round_to_zero = w[63:32] + {31'h0000_0000, sgn & inexact};
  endfunction

  // =====================================================
  // Shift primitives
  bssu_pkg::bssu_rsp_s     set_rsp;
  logic [5:0]              cnt;
  logic                    sgn;
  logic [63:0]             wide_l;
  logic [63:0]             wide_r;
  logic [63:0]             wide_a;
  logic                    left_ovf;

  // Bit set is its own unit, selected below
  bssu_core u_core
  (
    .i_req (i_req),
    .o_rsp (set_rsp)
  );

  always_comb
  begin
    cnt      = sat_count(i_req.count);
    sgn      = i_req.src[`BSSU_WORD_W-1];
    wide_l   = shift_left(i_req.src, cnt);
    wide_r   = shift_right(i_req.src, cnt, 1'b0);
    wide_a   = shift_right(i_req.src, cnt, sgn);
    left_ovf = left_overflow(wide_l, sgn);
  end

  // =====================================================
  // Candidate results, one per shift
  logic [`BSSU_WORD_W-1:0] res_shl_log;
  logic [`BSSU_WORD_W-1:0] res_shr_log;
  logic [`BSSU_WORD_W-1:0] res_shl_ari;
  logic [`BSSU_WORD_W-1:0] res_shr_ari;
  logic [`BSSU_WORD_W-1:0] res_shr_div;

  always_comb
  begin
    res_shl_log = wide_l[31:0];
    res_shr_log = wide_r[63:32];
    // On overflow the written word keeps the source sign
    res_shl_ari = left_ovf ? {sgn, wide_l[30:0]} : wide_l[31:0];
    res_shr_ari = wide_a[63:32];
    // Count 32 on a negative source rounds up to zero
    res_shr_div = round_to_zero(wide_a, sgn);
  end

  // =====================================================
  // Result select
  logic [`BSSU_WORD_W-1:0] nxt_result;
  logic                    nxt_overflow;

  always_comb
  begin
    nxt_result = `BSSU_RESET_DATA;
    case (i_req.op)
      bssu_pkg::BSSU_OP_SHL_LOG:
      begin
        nxt_result = res_shl_log;
      end
      bssu_pkg::BSSU_OP_SHR_LOG:
      begin
        nxt_result = res_shr_log;
      end
      bssu_pkg::BSSU_OP_SHL_ARI:
      begin
        nxt_result = res_shl_ari;
      end
      bssu_pkg::BSSU_OP_SHR_ARI:
      begin
        nxt_result = res_shr_ari;
      end
      bssu_pkg::BSSU_OP_SHR_DIV:
      begin
        nxt_result = res_shr_div;
      end
      bssu_pkg::BSSU_OP_SET_BIT:
      begin
        nxt_result = set_rsp.result;
      end
      default:
      begin
        nxt_result = `BSSU_RESET_DATA;
      end
    endcase
  end

  // =====================================================
  // Fault select; only the arithmetic left shift can leave the word range
  always_comb
  begin
    nxt_overflow = 1'b0;
    case (i_req.op)
      bssu_pkg::BSSU_OP_SHL_ARI:
      begin
        nxt_overflow = left_ovf;
      end
      bssu_pkg::BSSU_OP_SHR_DIV:
      begin
        // Rounding toward zero cannot leave the word range
        nxt_overflow = 1'b0;
      end
      bssu_pkg::BSSU_OP_SET_BIT:
      begin
        nxt_overflow = set_rsp.overflow;
      end
      default:
      begin
        nxt_overflow = 1'b0;
      end
    endcase
  end

  // =====================================================
  // Answer strobe, one cycle after each request
  always_ff @(posedge i_clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      o_valid <= 1'b0;
    end
    else
    begin
      o_valid <= i_valid;
    end
  end

  // =====================================================
  // Result register holds the last answer between requests
  always_ff @(posedge i_clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      o_result <= `BSSU_RESET_DATA;
    end
    else if (i_valid)
    begin
      o_result <= nxt_result;
    end
  end

  // =====================================================
  // Fault pulse, raised alongside the result of the same request
  always_ff @(posedge i_clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      o_overflow <= 1'b0;
    end
    else
    begin
      o_overflow <= i_valid & nxt_overflow;
    end
  end
endmodule

// File: rtl/bssu_consts.svh
// Notes on behaviour
// - Shift counts above 32 act as 32
// - Shift result drops bits past word ends
// - Logical left fills zeros, never overflows
// - Logical right fills zeros, unsigned divide
// - Arithmetic left overflows when shifted-out bit or new sign bit differs sign
// - On overflow, result sign equals source sign
// - Arithmetic right replicates sign, rounds down
// - Dividing right adds one for negative inexact
`ifndef BSSU_CONSTS_SVH
`define BSSU_CONSTS_SVH
`define BSSU_WORD_W      32
`define BSSU_CNT_W       32
`define BSSU_MAX_SHIFT   32
`define BSSU_POS_W       5
`define BSSU_RESET_DATA  32'h0000_0000
`endif

// File: rtl/bssu_pkg.sv
`include "bssu_consts.svh"
package bssu_pkg;
  typedef enum logic [2:0] {
    BSSU_OP_SHL_LOG = 3'h0,
    BSSU_OP_SHR_LOG = 3'h1,
    BSSU_OP_SHL_ARI = 3'h2,
    BSSU_OP_SHR_ARI = 3'h3,
    BSSU_OP_SHR_DIV = 3'h4,
    BSSU_OP_SET_BIT = 3'h5
  } bssu_op_e;

  typedef struct packed {
    bssu_op_e                  op;
    logic [`BSSU_CNT_W-1:0]    count;
    logic [`BSSU_WORD_W-1:0]   src;
  } bssu_req_s;

  typedef struct packed {
    logic [`BSSU_WORD_W-1:0]   result;
    logic                      overflow;
  } bssu_rsp_s;
endpackage

// File: rtl/bssu_core.sv
`timescale 1ns/1ps
`include "bssu_consts.svh"
module bssu_core
(
  input  wire bssu_pkg::bssu_req_s i_req,
  output bssu_pkg::bssu_rsp_s      o_rsp
);
  // =====================================================
  // Single bit set; the position wraps within the word
  always_comb
  begin
    o_rsp.overflow = 1'b0;
    o_rsp.result   = i_req.src | (32'h0000_0001 << i_req.count[`BSSU_POS_W-1:0]);
  end
endmodule

// File: sim/bssu_regf.sv
`timescale 1ns/1ps
module bssu_regf
(
  input  wire logic        i_clock,
  input  wire logic        i_we,
  input  wire logic [31:0] i_d,
  output logic      [31:0] o_q
);
  // Destination register takes each answered result
  always_ff @(posedge i_clock)
    if (i_we)
      o_q <= i_d;
endmodule

// File: sim/bssu_props.sv
`timescale 1ns/1ps
module bssu_props
(
  input wire logic                i_clock,
  input wire logic                i_nrst,
  input wire logic                i_valid,
  input wire bssu_pkg::bssu_req_s i_req,
  input wire logic                o_valid,
  input wire logic [31:0]         o_result,
  input wire logic                o_overflow
);
  // ====================
  // Properties
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire [2:0] op = i_req.op;
  wire       big = i_req.count > 31;
  AST_VLD: assert property (i_valid |=> o_valid) else $error("no answer");
  AST_IDLE: assert property (!i_valid |=> !o_valid && $stable(o_result)) else $error("idle");
  AST_NOOV: assert property (i_valid && op inside {0, 1, 3, 5} |=> !o_overflow)
    else $error("bad fault");
  AST_SAT: assert property (i_valid && op == 0 && big |=> o_result == 0) else $error("sat");
  AST_SET: assert property (i_valid && op == 5 |=> o_result[$past(i_req.count[4:0])])
    else $error("bit");
  AST_SIGN: assert property (i_valid && op == 2 ##1 o_overflow |-> o_result[31] ==
    $past(i_req.src[31])) else $error("sign");
  AST_ASR: assert property (i_valid && op == 3 && big |=> o_result == {32{$past(i_req.src[31])}})
    else $error("asr");
  AST_DIV: assert property (i_valid && op == 4 && big |=> o_result == 0) else $error("div");
  cover property (i_valid && op == 2 ##1 o_overflow);
  cover property (i_valid ##1 i_valid);
  cover property (i_valid && i_req.count > 32);
endmodule
bind bssu_top bssu_props u_props (.i_clock(i_clock), .i_nrst(i_nrst), .i_valid(i_valid),
  .i_req(i_req), .o_valid(o_valid), .o_result(o_result), .o_overflow(o_overflow));

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic                i_clock = 0, i_nrst = 0, i_valid = 0, o_valid, o_overflow;
  logic [31:0]         o_result, regq;
  bssu_pkg::bssu_req_s i_req = '0;
  logic [32:0]         q[$];
  int                  n_errors = 0, checked = 0, cyc = 0, k, o;
  integer              seed = 32'h162e;
  logic [32:0]         exp_r;
  logic [31:0]         wb_exp;
  logic                wb_due = 0;
  always #2.5 i_clock = ~i_clock;
  bssu_top uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_valid(i_valid), .i_req(i_req),
    .o_valid(o_valid), .o_result(o_result), .o_overflow(o_overflow));
  bssu_regf rf (.i_clock(i_clock), .i_we(o_valid), .i_d(o_result), .o_q(regq));
  // ====================
  // Reference and drivers
  function automatic logic [32:0] mdl(bssu_pkg::bssu_req_s r);
    logic [63:0] w;
    logic [31:0] s, a;
    logic        v;
    int          n;
    s = r.src;
    n = r.count > 32 ? 32 : r.count;
    w = {{32{s[31]}}, s} << n;
    a = $signed(s) >>> n;
    v = w[63:31] != {33{s[31]}};
    case (r.op)
      3'h0: return {w[31:0], 1'b0};
      3'h1: return {s >> n, 1'b0};
      3'h2: return {v ? s[31] : w[31], w[30:0], v};
      3'h3: return {a, 1'b0};
      3'h4: return {a + (s[31] && (s & ~(64'hffffffffffffffff << n)) != 0), 1'b0};
      3'h5: return {s | 32'h1 << r.count[4:0], 1'b0};
      default: return 33'h0;
    endcase
  endfunction
  task go(int op, int c, int s);
    @(posedge i_clock);
    #1 i_valid = 1;
    i_req = {op[2:0], c, s};
    q.push_back(mdl(i_req));
  endtask
  task idle();
    @(posedge i_clock);
    #1 i_valid = 0;
  endtask
  task chk(logic [32:0] got, logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_wb(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t wb got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test();
    if (q.size() != 0)
      n_errors++;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    #2;
    if (wb_due)
      chk_wb(regq, wb_exp);
    wb_due = o_valid;
    if (o_valid)
    begin
      exp_r  = q.pop_front();
      wb_exp = exp_r[32:1];
      chk({o_result, o_overflow}, exp_r);
    end
    if (++cyc == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // ====================
  // Tests
  initial
  begin
    repeat (6) @(posedge i_clock);
    #1 i_nrst = 1;
    repeat (2) @(posedge i_clock);
    for (o = 0; o < 7; o++)
      for (k = 0; k < 40; k++)
        go(o, k < 35 ? k : $random(seed), k[0] ? $random(seed) : {k[1], 31'h5});
    idle();
    $display("test sweep done");
    for (k = 0; k < 60; k++)
    begin
      go($unsigned($random(seed)) % 6, $random(seed) % 40, $random(seed));
      idle();
    end
    $display("test spaced done");
    repeat (3) @(posedge i_clock);
    stop_test();
  end
endmodule
